// ===== inc/osfl_pkg.sv
package osfl_pkg;
	// ----------------------------------------
	// word layout
	// ----------------------------------------
	localparam int NUM_OUT = 8;
	localparam int WORD_BITS = 16;
	localparam int CMD_LSB = 0;
	localparam int OLEN_LSB = 8;
	localparam int STAT_LSB = 0;
	localparam logic [7:0] STAT_HIGH_FILL = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] OLEN_RESET = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// ----------------------------------------
	// frame length check: 16 + n * 8 clocks
	// ----------------------------------------
	localparam logic [4:0] CNT_RESET = 5'h00;
	localparam logic [4:0] CNT_BASE = 5'h10;
	localparam logic [4:0] CNT_WRAP = 5'h17;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int FILTER_MIN_US = 100;
	localparam int FILTER_MAX_US = 300;
	localparam int FILTER_TARGET_US = 200;
	localparam int FILTER_CYCLES = FILTER_TARGET_US * 1000 / CLK_PERIOD_NS;
endpackage

// ===== inc/osfl_link_if.sv
// ----------------------------------------
// core to serial link carrier
// ----------------------------------------
interface osfl_link_if;
	logic [15:0] status;
	logic [15:0] word;
	logic word_ok;

	modport core
	(
		output status,
		input word,
		input word_ok
	);
	modport link
	(
		input status,
		output word,
		output word_ok
	);
endinterface

// ===== logic/osfl_spi_link.sv
module osfl_spi_link
(
	input wire logic sclk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic di,
	output logic sdo,
	osfl_link_if.link lk
);
	// ----------------------------------------
	// frame clock counter
	// ----------------------------------------
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic [15:0] sreg;
	logic [15:0] next_sreg;
	logic [15:0] shift_src;
	logic ok;
	wire frame_clr_n = rst_n & ~cs_n;
	wire first_bit = (cnt == osfl_pkg::CNT_RESET);

	// counts 0..16 then loops 17..23 back to 16
	assign next_cnt = (cnt == osfl_pkg::CNT_WRAP) ?
		osfl_pkg::CNT_BASE : cnt + 5'h01;

	// status word enters the shifter on the first edge
	assign shift_src = first_bit ? lk.status : sreg; // RULE20
	assign next_sreg = {shift_src[14:0], di};

	// counter cleared whenever chip select is high
	always_ff @(posedge sclk or negedge frame_clr_n)
	begin
		if (!frame_clr_n)
			cnt <= osfl_pkg::CNT_RESET;
		else
			cnt <= next_cnt;
	end

	// ----------------------------------------
	// shifter and length flag
	// ----------------------------------------
	always_ff @(posedge sclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sreg <= osfl_pkg::WORD_RESET;
			ok <= 1'b0;
		end
		else
		begin
			sreg <= next_sreg;
			ok <= (next_cnt == osfl_pkg::CNT_BASE); // RULE18
		end
	end

	// last sixteen bits in, held after clock stops
	assign lk.word = sreg;
	assign lk.word_ok = ok;
	assign sdo = first_bit ? lk.status[15] : sreg[15];
endmodule // osfl_spi_link

// ===== logic/osfl_fault_logic.sv
// What this block does
// RULE1 - overtemperature cuts output without any clock
// RULE2 - overtemperature affects only its own output
// RULE3 - overtemperature shows as status one
// RULE4 - output returns after cooling unless commanded off
// RULE5 - load supply overvoltage forces all off, restores
// RULE6 - logic supply overvoltage is never acted on
// RULE7 - open load checked only on commanded-off outputs
// RULE8 - detect current per output, off after reset
// RULE9 - detect current off without logic supply/enable
// RULE10 - chip select rise starts open-load filter timer
// RULE11 - open load latched until host reads it
// RULE12 - shorted load cycles only its own output
// RULE13 - short faults reported regardless of current enables
// RULE14 - undervoltage forces off, resets logic on recovery
// RULE15 - command bits 0-7 outputs, 8-15 currents
// RULE16 - status bits 0-7 faults, 8-15 zero
// RULE17 - command applied on chip select rising edge
// RULE18 - frames of 16 plus multiples of 8 only
// RULE19 - filter timer is a clocked counter
// RULE20 - status loaded into shifter at frame start
module osfl_fault_logic
#(
	parameter int NUM_OUT = osfl_pkg::NUM_OUT,
	parameter int FILTER_CYCLES = osfl_pkg::FILTER_CYCLES
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic di,
	output logic sdo,
	input wire logic enable,
	input wire logic load_supply_ov,
	input wire logic load_supply_uv,
	input wire logic logic_supply_uv,
	input wire logic [7:0] over_temp,
	input wire logic [7:0] over_current,
	input wire logic [7:0] open_load_cmp,
	output logic [7:0] out_on,
	output logic [7:0] ol_current_on,
	output logic [7:0] fault_status
);
	localparam int TW = $clog2(FILTER_CYCLES + 1);
	localparam logic [TW-1:0] TIMER_LOAD = TW'(FILTER_CYCLES);
	localparam logic [TW-1:0] TIMER_ZERO = '0;

	// ----------------------------------------
	// serial link
	// ----------------------------------------
	osfl_link_if lk ();

	osfl_spi_link u_link
	(
		.sclk(sclk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.di(di),
		.sdo(sdo),
		.lk(lk.link)
	);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [1:0] cs_meta;
	logic cs_s;
	logic cs_d;
	logic [2:0] sup_meta;
	logic [2:0] sup_s;
	logic [7:0] ot_meta;
	logic [7:0] ot_s;
	logic [7:0] oc_meta;
	logic [7:0] oc_s;
	logic [7:0] ol_meta;
	logic [7:0] ol_s;

	// chip select three stages, enable and supply levels two stages
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_meta <= 2'h3;
			cs_s <= 1'b1;
			cs_d <= 1'b1;
			sup_meta <= 3'h0;
			sup_s <= 3'h0;
		end
		else
		begin
			cs_meta <= {cs_meta[0], cs_n};
			cs_s <= cs_meta[1];
			cs_d <= cs_s;
			sup_meta <= {enable, load_supply_uv, logic_supply_uv};
			sup_s <= sup_meta;
		end
	end

	// per-output fault indications, two stages
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ot_meta <= 8'h00;
			ot_s <= 8'h00;
			oc_meta <= 8'h00;
			oc_s <= 8'h00;
			ol_meta <= 8'h00;
			ol_s <= 8'h00;
		end
		else
		begin
			ot_meta <= over_temp;
			ot_s <= ot_meta;
			oc_meta <= over_current;
			oc_s <= oc_meta;
			ol_meta <= open_load_cmp;
			ol_s <= ol_meta;
		end
	end

	// ----------------------------------------
	// frame events and sleep
	// ----------------------------------------
	wire en_s = sup_s[2];
	wire load_uv_s = sup_s[1];
	wire logic_uv_s = sup_s[0];
	wire frame_start = cs_d & ~cs_s;
	wire frame_end = cs_s & ~cs_d;
	wire take_word = frame_end & lk.word_ok; // RULE18
	// sleep or undervoltage holds the logic in reset state
	wire logic_clear = ~en_s | logic_uv_s | load_uv_s; // RULE14

	// ----------------------------------------
	// command and detect current registers
	// ----------------------------------------
	logic [7:0] cmd;
	logic [7:0] olen;
	logic [7:0] next_cmd;
	logic [7:0] next_olen;

	assign next_cmd = logic_clear ? osfl_pkg::CMD_RESET :
		take_word ? lk.word[osfl_pkg::CMD_LSB +: 8] : cmd; // RULE17
	assign next_olen = logic_clear ? osfl_pkg::OLEN_RESET :
		take_word ? lk.word[osfl_pkg::OLEN_LSB +: 8] : olen; // RULE15

	// command word lands only on an accepted frame end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd <= osfl_pkg::CMD_RESET;
			olen <= osfl_pkg::OLEN_RESET; // RULE8
		end
		else
		begin
			cmd <= next_cmd;
			olen <= next_olen;
		end
	end

	// ----------------------------------------
	// open-load filter timer
	// ----------------------------------------
	logic [TW-1:0] timer;
	logic [TW-1:0] next_timer;
	wire timer_done = (timer == TIMER_ZERO);

	// reload on every frame end, count down to zero
	assign next_timer = frame_end ? TIMER_LOAD :
		timer_done ? TIMER_ZERO : timer - TW'(1); // RULE10

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			timer <= TIMER_ZERO;
		else
			timer <= next_timer; // RULE19
	end

	// ----------------------------------------
	// open-load latch
	// ----------------------------------------
	logic [7:0] ol_latch;
	logic [7:0] next_latch;
	logic [7:0] ol_set;

	// only off outputs with current enabled, after the filter
	assign ol_set = ol_s & ~cmd & olen & {8{timer_done}}; // RULE7
	// read at frame start clears, a new set wins
	assign next_latch = logic_clear ? osfl_pkg::LATCH_RESET :
		(frame_start ? 8'h00 : ol_latch) | ol_set; // RULE11

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ol_latch <= osfl_pkg::LATCH_RESET;
		else
			ol_latch <= next_latch;
	end

	// ----------------------------------------
	// status word and snapshot
	// ----------------------------------------
	logic [7:0] snap;
	logic [7:0] live_fault;

	// thermal and short faults need no current enable
	assign live_fault = ot_s | oc_s | ol_latch; // RULE3 RULE13

	// snapshot frozen while a frame runs
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			snap <= 8'h00;
		else if (cs_s)
			snap <= live_fault; // RULE20
	end

	assign lk.status = {osfl_pkg::STAT_HIGH_FILL, snap}; // RULE16
	assign fault_status = snap;

	// ----------------------------------------
	// output gating
	// ----------------------------------------
	// no logic supply overvoltage input exists
	wire global_off = load_supply_ov | load_supply_uv
		| logic_supply_uv; // RULE5 RULE6 RULE14

	// unclocked per-output cut, command kept for recovery
	assign out_on = cmd & ~over_temp
		& {8{~global_off}}; // RULE1 RULE2 RULE4 RULE12

	// detect currents drop without supply or enable
	assign ol_current_on = olen & {8{enable & ~logic_supply_uv}}; // RULE9
endmodule // osfl_fault_logic

// ===== bench/osfl_fault_logic_asserts.sv
module osfl_chk
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sdo,
	input wire logic enable,
	input wire logic load_supply_ov,
	input wire logic load_supply_uv,
	input wire logic logic_supply_uv,
	input wire logic [7:0] over_temp,
	input wire logic [7:0] over_current,
	input wire logic [7:0] out_on,
	input wire logic [7:0] ol_current_on,
	input wire logic [7:0] fault_status
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// link idle, no supply undervoltage, faults steady
	sequence quiet6;
		(cs_n && enable && !load_supply_uv && !logic_supply_uv
			&& $stable(over_temp) && $stable(over_current))[*6];
	endsequence
	sequence frame6;
		(!cs_n && enable && !load_supply_uv && !logic_supply_uv)[*6];
	endsequence
	sequence uv5;
		(load_supply_uv || logic_supply_uv)[*5];
	endsequence
	// overvoltage pulse of three cycles
	property ov_back;
		logic [7:0] v;
		(quiet6 ##0 (!load_supply_ov, v = out_on))
			##1 (load_supply_ov && cs_n)[*3] ##1 !load_supply_ov
			|-> out_on == v;
	endproperty
	chk_temp_cuts: assert property (
		(out_on & over_temp) == 8'h00) else $error("hot output on");
	chk_ov_off: assert property (
		load_supply_ov |-> out_on == 8'h00) else $error("ov output on");
	chk_ov_back: assert property (ov_back)
		else $error("outputs not restored");
	chk_uv_off: assert property (
		uv5 |-> out_on == 8'h00 && ol_current_on == 8'h00)
		else $error("uv output on");
	chk_cur_gate: assert property (
		!enable || logic_supply_uv |-> ol_current_on == 8'h00)
		else $error("current on while asleep");
	chk_cmd_hold: assert property (
		frame6 |-> $stable(ol_current_on) && $stable(out_on))
		else $error("command moved mid frame");
	chk_stat_flags: assert property (
		quiet6 |-> ((over_temp | over_current) & ~fault_status) == 8'h00)
		else $error("fault not flagged");
	chk_sdo_zero: assert property (
		$fell(cs_n) ##1 (!cs_n)[*4] |-> !sdo)
		else $error("status msb not zero");
endmodule // osfl_chk

bind osfl_fault_logic osfl_chk i_chk (.mclk, .rst_n, .cs_n, .sdo,
	.enable, .load_supply_ov, .load_supply_uv, .logic_supply_uv,
	.over_temp, .over_current, .out_on, .ol_current_on, .fault_status);

// ===== bench/osfl_host.sv
module osfl_host
(
	output logic sclk,
	output logic cs_n,
	output logic di,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 100ps;
	// one frame of n clocks, msb first, clock still outside
	task automatic xfer(input int n, input logic [31:0] w,
		output logic [31:0] r);
		r = '0;
		cs_n = 1'b0;
		#50;
		for (int i = n - 1; i >= 0; i--)
		begin
			di = w[i];
			#3 r = {r[30:0], sdo};
			sclk = 1'b1;
			#3 sclk = 1'b0;
		end
		#3 cs_n = 1'b1;
		di = ~di; // released line shows no stale bit
		#50;
	endtask
	// idle levels
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		di = 1'b0;
	end
endmodule // osfl_host

// ===== bench/osfl_fault_logic_test.sv
module osfl_fault_logic_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, rst_n, sclk, cs_n, di, sdo, enable, ov, luv, suv;
	logic [7:0] ot, oc, olc, out_on, olc_on, fst;
	logic [15:0] m_cmd, w;
	logic [31:0] r;
	int error_cnt = 0;
	int checks_done = 0;
	int lens[5] = '{15, 24, 17, 23, 16};
	osfl_fault_logic #(.FILTER_CYCLES(20)) i_dut (.mclk, .rst_n, .sclk,
		.cs_n, .di, .sdo, .enable, .load_supply_ov(ov),
		.load_supply_uv(luv), .logic_supply_uv(suv), .over_temp(ot),
		.over_current(oc), .open_load_cmp(olc), .out_on,
		.ol_current_on(olc_on), .fault_status(fst));
	osfl_host i_host (.sclk, .cs_n, .di, .sdo);
	// clock and watchdog
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		#900us error_cnt++;
		conclude();
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic conclude();
		if (error_cnt == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// model of the gated outputs
	task automatic cmp();
		chk({olc_on, out_on}, {(enable && !suv) ? m_cmd[15:8] : 8'h00,
			(ov || luv || suv) ? 8'h00 : m_cmd[7:0] & ~ot});
	endtask
	// frame, returned word checked, model takes legal command
	task automatic send(input int n, input logic [15:0] a,
		input logic [15:0] c, input logic [7:0] s);
		i_host.xfer(n, {a, c}, r);
		if (n == 32)
			chk(r[15:0], a);
		if (n == 32 || n == 16)
			chk(n == 32 ? r[31:16] : r[15:0], {8'h00, s});
		if (n % 8 == 0)
			m_cmd = c;
		repeat (8) @(negedge mclk);
		cmp();
	endtask
	initial
	begin
		{rst_n, ov, luv, suv, ot, oc, olc, m_cmd} = '0;
		enable = 1'b1;
		void'($urandom(32'h44766EE9));
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		cmp();
		repeat (6)
			send(32, 16'($urandom), 16'($urandom), 8'h00);
		w = m_cmd;
		foreach (lens[i])
			send(lens[i], w, ~w, 8'h00);
		send(16, 0, 16'h00FF, 8'h00);
		ot = 8'h08;
		oc = 8'h40;
		repeat (6) @(negedge mclk);
		send(16, 0, 16'h00FF, 8'h48);
		oc = 8'h00;
		cmp();
		ot = 8'h00;
		repeat (6) @(negedge mclk);
		cmp();
		ov = 1'b1;
		@(negedge mclk);
		cmp();
		repeat (2) @(negedge mclk);
		ov = 1'b0;
		@(negedge mclk);
		cmp();
		olc = 8'hFF;
		send(16, 0, 16'h0302, 8'h00);
		chk({8'h00, fst}, 16'h0000);
		repeat (30) @(negedge mclk);
		chk({8'h00, fst}, 16'h0001);
		olc = 8'h00;
		send(16, 0, 16'h0302, 8'h01);
		send(16, 0, 16'h0302, 8'h00);
		enable = 1'b0;
		@(negedge mclk);
		cmp();
		repeat (6) @(negedge mclk);
		enable = 1'b1;
		m_cmd = 0;
		repeat (6) @(negedge mclk);
		cmp();
		send(16, 0, 16'hFFFF, 8'h00);
		luv = 1'b1;
		m_cmd = 0;
		repeat (6) @(negedge mclk);
		cmp();
		luv = 1'b0;
		repeat (6) @(negedge mclk);
		cmp();
		conclude();
	end
endmodule // osfl_fault_logic_test
